/* File: inc/wlv_pkg.sv */
/*
  wlv_pkg: shared constants and types for the write-leveling link.
  assumes: included first; counts are in link-clock cycles unless named _clk, except CK_HALF, in controller clocks.
*/
`default_nettype none
package wlv_pkg;
  // lane geometry
  localparam int LANES = 2;
  localparam int LANE_W = 8;
  localparam int DQ_W = 16;
  localparam int ADDR_W = 16;
  // mode register one fields
  localparam int LEVEL_BIT = 7;
  localparam int OUT_OFF_BIT = 12;
  // link timing, link-clock cycles
  localparam int MODE_TO_CMD_NCK = 12;
  localparam int MODE_CYCLE_NCK = 4;
  localparam int STROBE_EN_NCK = 25;
  localparam int FIRST_STROBE_NCK = 40;
  localparam int LVL_OUT_NCK = 2;
  localparam int LVL_ERR_NCK = 1;
  localparam int TERM_OFF_NCK = 4;
  // controller clocks per link-clock half period
  localparam int CK_HALF = 2;
  // controller register map
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_RESULT = 12'h008;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_OUT_OFF_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_FAIL_BIT = 2;
  localparam int RES_UPPER_LSB = 8;
  localparam int RES_LOCK_LSB = 16;
  // link commands
  typedef enum logic [1:0] {
    WLV_CMD_DES = 2'h0,
    WLV_CMD_NOP = 2'h1,
    WLV_CMD_MRS = 2'h2,
    WLV_CMD_OTHER = 2'h3
  } wlv_cmd_t;
endpackage
`default_nettype wire

/* File: inc/wlv_link_if.sv */
/*
  wlv_link_if: pins between the leveling controller and the memory device.
  assumes: controller makes ck; undriven strobe and dq lines read as zero.
*/
`timescale 1ns/100ps
`default_nettype none
interface wlv_link_if;
  logic ck;
  wlv_pkg::wlv_cmd_t cmd;
  logic mode_register_one_sel;
  logic [wlv_pkg::ADDR_W-1:0] addr;
  logic termination_enable_input;
  logic [wlv_pkg::LANES-1:0] strobe_o;
  logic strobe_oe_n;
  logic [wlv_pkg::DQ_W-1:0] dq_o;
  logic dq_oe_n;
  logic upper_lane_strobe;
  logic lower_lane_strobe;
  logic [wlv_pkg::DQ_W-1:0] dq;
  // wire resolution
  assign upper_lane_strobe = ~strobe_oe_n & strobe_o[1];
  assign lower_lane_strobe = ~strobe_oe_n & strobe_o[0];
  assign dq = dq_oe_n ? 16'h0000 : dq_o;
  modport ctl (
    output ck, cmd, mode_register_one_sel, addr, termination_enable_input,
    output strobe_o, strobe_oe_n,
    input dq
  );
  modport dev (
    input ck, cmd, mode_register_one_sel, addr, termination_enable_input,
    input upper_lane_strobe, lower_lane_strobe,
    output dq_o, dq_oe_n
  );
endinterface
`default_nettype wire

/* File: hw/wlv_device.sv */
/*
  wlv_device: leveling logic of the memory device end, on the link clock.
  assumes: commands and termination change at the link clock falling edge.
*/
`timescale 1ns/100ps
`default_nettype none
module wlv_device (
  // link
  wlv_link_if.dev link,
  // user side, link-clock domain
  input wire logic reset,
  output logic leveling_active,
  output logic output_disabled,
  output logic strobe_term_on,
  output logic dq_term_on,
  output logic cmd_ready,
  output logic mrs_ready,
  output logic illegal_cmd
);
  logic lvl_q, lvl_d, odis_q, odis_d, sterm_q, sterm_d, dterm_q, dterm_d;
  logic ill_q, ill_d, oe_n_q, oe_n_d;
  logic [7:0] mod_q, mod_d, mrd_q, mrd_d;
  logic [wlv_pkg::LANES-1:0] stb, pos_q, neg_q;
  logic is_mrs;

  assign stb = {link.upper_lane_strobe, link.lower_lane_strobe};
  assign is_mrs = (link.cmd == wlv_pkg::WLV_CMD_MRS) & link.mode_register_one_sel;

  always_comb begin
    lvl_d = lvl_q;
    odis_d = odis_q;
    mod_d = (mod_q != 8'h00) ? mod_q - 8'h01 : mod_q;
    mrd_d = (mrd_q != 8'h00) ? mrd_q - 8'h01 : mrd_q;
    ill_d = 1'b0;
    if (is_mrs) begin
      lvl_d = link.addr[wlv_pkg::LEVEL_BIT];
      odis_d = link.addr[wlv_pkg::OUT_OFF_BIT];
      mod_d = 8'(wlv_pkg::MODE_TO_CMD_NCK);
      mrd_d = 8'(wlv_pkg::MODE_CYCLE_NCK);
      ill_d = (mrd_q != 8'h00);
    end
    if (link.cmd == wlv_pkg::WLV_CMD_OTHER) begin
      ill_d = lvl_q | (mod_q != 8'h00);
    end
    if ((link.cmd == wlv_pkg::WLV_CMD_MRS) & ~link.mode_register_one_sel & lvl_q) begin
      ill_d = 1'b1;
    end
    // leveling: termination input reaches strobes only
    sterm_d = link.termination_enable_input;
    dterm_d = link.termination_enable_input & ~lvl_q;
    // pins drive, undefined at entry and for one cycle past the exit write
    oe_n_d = ~((lvl_d | (mod_d != 8'h00 && lvl_q)) & ~odis_d);
  end

  always_ff @(posedge link.ck) begin
    if (reset) begin
      lvl_q <= 1'b0;
      odis_q <= 1'b0;
      mod_q <= 8'h00;
      mrd_q <= 8'h00;
      ill_q <= 1'b0;
      sterm_q <= 1'b0;
      dterm_q <= 1'b0;
      oe_n_q <= 1'b1;
      pos_q <= '0;
    end else begin
      lvl_q <= lvl_d;
      odis_q <= odis_d;
      mod_q <= mod_d;
      mrd_q <= mrd_d;
      ill_q <= ill_d;
      sterm_q <= sterm_d;
      dterm_q <= dterm_d;
      oe_n_q <= oe_n_d;
      pos_q <= stb;
    end
  end

  // strobe level in the low half of the clock
  always_ff @(negedge link.ck) begin
    if (reset) begin
      neg_q <= '0;
    end else begin
      neg_q <= stb;
    end
  end

  genvar l;
  generate
    for (l = 0; l < wlv_pkg::LANES; l++) begin : g_lane
      logic pend_q, pend_d, smp_q, smp_d, out_q, out_d;
      logic [7:0] cnt_q, cnt_d;
      always_comb begin
        pend_d = pend_q;
        smp_d = smp_q;
        cnt_d = cnt_q;
        out_d = out_q;
        if (pend_q) begin
          cnt_d = cnt_q - 8'h01;
          if (cnt_q == 8'h01) begin
            out_d = smp_q;
            pend_d = 1'b0;
          end
        end
        if (lvl_q & stb[l] & ~pos_q[l]) begin
          // rise after the falling edge means clock was low
          smp_d = neg_q[l];
          cnt_d = 8'(wlv_pkg::LVL_OUT_NCK);
          pend_d = 1'b1;
        end
      end
      always_ff @(posedge link.ck) begin
        if (reset) begin
          pend_q <= 1'b0;
          smp_q <= 1'b0;
          cnt_q <= 8'h00;
          out_q <= 1'b0;
        end else begin
          pend_q <= pend_d;
          smp_q <= smp_d;
          cnt_q <= cnt_d;
          out_q <= out_d;
        end
      end
      // one flop feeds every bit of the lane
      assign link.dq_o[l*wlv_pkg::LANE_W +: wlv_pkg::LANE_W] = {wlv_pkg::LANE_W{out_q}};
    end
  endgenerate

  assign link.dq_oe_n = oe_n_q;
  assign leveling_active = lvl_q;
  assign output_disabled = odis_q;
  assign strobe_term_on = sterm_q;
  assign dq_term_on = dterm_q;
  assign cmd_ready = (mod_q == 8'h00);
  assign mrs_ready = (mrd_q == 8'h00);
  assign illegal_cmd = ill_q;
endmodule
`default_nettype wire

/* File: hw/wlv_controller.sv */
/*
  wlv_controller: write-leveling sequencer with an APB register slave.
  assumes: clk at 125 MHz; link clock made here by a divider; APB on clk.
*/
// Behaviour
// - mode register one bit 7 enters/exits leveling
// - leveling termination switches strobe pair only
// - output enabled restricts allowed termination values
// - only nop, deselect, exit write while leveling
// - level one rank; others output-disabled
// - termination waits mode-to-command delay
// - strobe driven low after strobe-enable delay
// - single strobe edge after first-strobe delay
// - device returns sampled clock on lane bits
// - lane bit mismatch within output error window
// - step delay each sample; freeze on 0-to-1
// - each byte lane leveled on its own
// - data pins undefined on entering leveling
// - exit: strobes off, termination low, then write
// - after exit wait mode and cycle delays
`timescale 1ns/100ps
`default_nettype none
module wlv_controller #(
  parameter int DLY_W = 3,
  parameter int CK_HALF = wlv_pkg::CK_HALF
) (
  // system
  input wire logic clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link
  wlv_link_if.ctl link
);
  localparam int PERIOD = 2 * CK_HALF;
  localparam int PH_W = (PERIOD > 2) ? $clog2(PERIOD) : 1;
  localparam int SAMPLE_CLK = (wlv_pkg::LVL_OUT_NCK + wlv_pkg::LVL_ERR_NCK + 2) * PERIOD + 4;
  localparam int PULSE_END = (1 << DLY_W) + PERIOD;
  localparam int L = wlv_pkg::LANES;

  generate
    if (CK_HALF < 1 || DLY_W < 1 || DLY_W > 8 || PULSE_END > 255 || SAMPLE_CLK > 255) begin : g_bad
      $error("wlv_controller: unsupported parameters");
    end
  endgenerate

  typedef enum logic [10:0] {
    S_IDLE = 11'h001,
    S_MRS_ON = 11'h002,
    S_W_MOD = 11'h004,
    S_W_EN = 11'h008,
    S_W_FIRST = 11'h010,
    S_PULSE = 11'h020,
    S_SAMPLE = 11'h040,
    S_STOP = 11'h080,
    S_TERM = 11'h100,
    S_MRS_OFF = 11'h200,
    S_W_EXIT = 11'h400
  } wlv_state_t;

  function automatic logic wlv_major(input logic [wlv_pkg::LANE_W-1:0] v);
    logic [7:0] n;
    n = 8'h00;
    for (int i = 0; i < wlv_pkg::LANE_W; i++) begin
      n = n + 8'(v[i]);
    end
    return n > 8'(wlv_pkg::LANE_W / 2);
  endfunction

  // link clock divider
  logic [PH_W-1:0] ph_q, ph_d;
  logic ck_q, ck_d, tick;
  always_comb begin
    ph_d = (ph_q == PH_W'(PERIOD - 1)) ? '0 : ph_q + PH_W'(1);
    ck_d = (ph_d < PH_W'(CK_HALF));
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      ph_q <= '0;
      ck_q <= 1'b1;
    end else begin
      ph_q <= ph_d;
      ck_q <= ck_d;
    end
  end
  // commands change together with the falling edge
  assign tick = (ph_q == PH_W'(CK_HALF - 1));

  // feedback synchroniser, a bit counts once stages two and three agree
  logic [wlv_pkg::DQ_W-1:0] s1_q, s2_q, s3_q, fb_q, fb_d;
  always_comb begin
    fb_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & fb_q);
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      fb_q <= '0;
    end else begin
      s1_q <= link.dq;
      s2_q <= s1_q;
      s3_q <= s2_q;
      fb_q <= fb_d;
    end
  end

  // sequencer
  wlv_state_t st_q, st_d;
  wlv_pkg::wlv_cmd_t cmd_q, cmd_d;
  logic mr1_q, mr1_d, term_q, term_d, soe_n_q, soe_n_d, done_q, done_d, fail_q, fail_d;
  logic [wlv_pkg::ADDR_W-1:0] addr_q, addr_d;
  logic [7:0] cnt_q, cnt_d;
  logic [L-1:0] stb_q, stb_d, lock_q, lock_d, prev_q, prev_d, seen_q, seen_d;
  logic [L-1:0][DLY_W-1:0] dly_q, dly_d;
  logic start_q, start_d, odis_q, odis_d;

  always_comb begin
    logic f;
    logic over;
    f = 1'b0;
    over = 1'b0;
    st_d = st_q;
    cmd_d = cmd_q;
    mr1_d = mr1_q;
    addr_d = addr_q;
    term_d = term_q;
    soe_n_d = soe_n_q;
    stb_d = stb_q;
    cnt_d = cnt_q;
    lock_d = lock_q;
    prev_d = prev_q;
    seen_d = seen_q;
    dly_d = dly_q;
    done_d = done_q;
    fail_d = fail_q;
    if (tick) begin
      cmd_d = wlv_pkg::WLV_CMD_NOP;
      mr1_d = 1'b0;
    end
    unique case (st_q)
      S_IDLE: if (start_q) begin
        lock_d = '0;
        seen_d = '0;
        prev_d = '0;
        dly_d = '0;
        done_d = 1'b0;
        fail_d = 1'b0;
        st_d = S_MRS_ON;
      end
      S_MRS_ON: if (tick) begin
        cmd_d = wlv_pkg::WLV_CMD_MRS;
        mr1_d = 1'b1;
        addr_d = '0;
        addr_d[wlv_pkg::LEVEL_BIT] = 1'b1;
        addr_d[wlv_pkg::OUT_OFF_BIT] = odis_q;
        cnt_d = 8'(wlv_pkg::MODE_TO_CMD_NCK);
        st_d = S_W_MOD;
      end
      S_W_MOD: if (tick) begin
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == 8'h01) begin
          term_d = 1'b1;
          cnt_d = 8'(wlv_pkg::STROBE_EN_NCK);
          st_d = S_W_EN;
        end
      end
      S_W_EN: if (tick) begin
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == 8'h01) begin
          soe_n_d = 1'b0;
          stb_d = '0;
          cnt_d = 8'(wlv_pkg::FIRST_STROBE_NCK);
          st_d = S_W_FIRST;
        end
      end
      S_W_FIRST: if (tick) begin
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == 8'h01) begin
          cnt_d = 8'h00;
          st_d = S_PULSE;
        end
      end
      S_PULSE: begin
        cnt_d = cnt_q + 8'h01;
        for (int i = 0; i < L; i++) begin
          stb_d[i] = (cnt_q >= 8'(dly_q[i])) && (cnt_q < 8'(dly_q[i]) + 8'(PERIOD));
        end
        if (cnt_q == 8'(PULSE_END)) begin
          stb_d = '0;
          cnt_d = 8'h00;
          st_d = S_SAMPLE;
        end
      end
      S_SAMPLE: begin
        cnt_d = cnt_q + 8'h01;
        // feedback read only once it is due
        if (cnt_q == 8'(SAMPLE_CLK)) begin
          for (int i = 0; i < L; i++) begin
            f = wlv_major(fb_q[i*wlv_pkg::LANE_W +: wlv_pkg::LANE_W]);
            if (!lock_q[i]) begin
              if (seen_q[i] && !prev_q[i] && f) begin
                lock_d[i] = 1'b1;
              end else begin
                prev_d[i] = f;
                seen_d[i] = 1'b1;
                if (dly_q[i] == {DLY_W{1'b1}}) begin
                  over = 1'b1;
                end else begin
                  dly_d[i] = dly_q[i] + DLY_W'(1);
                end
              end
            end
          end
          if ((&lock_d) || over) begin
            fail_d = ~(&lock_d);
            st_d = S_STOP;
          end else begin
            cnt_d = 8'h01;
            st_d = S_W_FIRST;
          end
        end
      end
      S_STOP: if (tick) begin
        soe_n_d = 1'b1;
        cnt_d = 8'(wlv_pkg::TERM_OFF_NCK + 1);
        st_d = S_TERM;
      end
      S_TERM: if (tick) begin
        term_d = 1'b0;
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == 8'h01) begin
          st_d = S_MRS_OFF;
        end
      end
      S_MRS_OFF: if (tick) begin
        cmd_d = wlv_pkg::WLV_CMD_MRS;
        mr1_d = 1'b1;
        addr_d = '0;
        cnt_d = 8'(wlv_pkg::MODE_TO_CMD_NCK);
        st_d = S_W_EXIT;
      end
      S_W_EXIT: if (tick) begin
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == 8'h01) begin
          done_d = 1'b1;
          st_d = S_IDLE;
        end
      end
      default: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= S_IDLE;
      cmd_q <= wlv_pkg::WLV_CMD_DES;
      mr1_q <= 1'b0;
      addr_q <= '0;
      term_q <= 1'b0;
      soe_n_q <= 1'b1;
      stb_q <= '0;
      cnt_q <= 8'h00;
      lock_q <= '0;
      prev_q <= '0;
      seen_q <= '0;
      dly_q <= '0;
      done_q <= 1'b0;
      fail_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cmd_q <= cmd_d;
      mr1_q <= mr1_d;
      addr_q <= addr_d;
      term_q <= term_d;
      soe_n_q <= soe_n_d;
      stb_q <= stb_d;
      cnt_q <= cnt_d;
      lock_q <= lock_d;
      prev_q <= prev_d;
      seen_q <= seen_d;
      dly_q <= dly_d;
      done_q <= done_d;
      fail_q <= fail_d;
    end
  end

  // apb slave, zero wait states
  logic [31:0] rd_q, rd_d;
  logic err_q, err_d;
  logic wr;
  assign wr = psel & penable & pwrite;
  always_comb begin
    rd_d = rd_q;
    err_d = err_q;
    start_d = wr && (paddr == wlv_pkg::ADDR_CTRL) && pwdata[wlv_pkg::CTRL_START_BIT];
    odis_d = odis_q;
    // out-disable value is held while a run is under way
    if (wr && paddr == wlv_pkg::ADDR_CTRL && st_q == S_IDLE) begin
      odis_d = pwdata[wlv_pkg::CTRL_OUT_OFF_BIT];
    end
    if (psel & ~penable) begin
      rd_d = 32'h0000_0000;
      err_d = 1'b0;
      unique case (paddr)
        wlv_pkg::ADDR_CTRL: rd_d[wlv_pkg::CTRL_OUT_OFF_BIT] = odis_q;
        wlv_pkg::ADDR_STATUS: begin
          rd_d[wlv_pkg::STAT_BUSY_BIT] = (st_q != S_IDLE);
          rd_d[wlv_pkg::STAT_DONE_BIT] = done_q;
          rd_d[wlv_pkg::STAT_FAIL_BIT] = fail_q;
        end
        wlv_pkg::ADDR_RESULT: begin
          rd_d[DLY_W-1:0] = dly_q[0];
          rd_d[wlv_pkg::RES_UPPER_LSB +: DLY_W] = dly_q[1];
          rd_d[wlv_pkg::RES_LOCK_LSB +: L] = lock_q;
        end
        default: err_d = 1'b1;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_q <= 32'h0000_0000;
      err_q <= 1'b0;
      start_q <= 1'b0;
      odis_q <= 1'b0;
    end else begin
      rd_q <= rd_d;
      err_q <= err_d;
      start_q <= start_d;
      odis_q <= odis_d;
    end
  end

  assign prdata = rd_q;
  assign pready = psel & penable;
  assign pslverr = psel & penable & err_q;
  assign link.ck = ck_q;
  assign link.cmd = cmd_q;
  assign link.mode_register_one_sel = mr1_q;
  assign link.addr = addr_q;
  assign link.termination_enable_input = term_q;
  assign link.strobe_o = stb_q;
  assign link.strobe_oe_n = soe_n_q;
endmodule
`default_nettype wire

/* File: test/wlv_link_properties.sv */
/*
  wlv_link_properties: checks on the wires between the two ends.
  assumes: ck comes from the controller; reset_link is synchronous to ck.
*/
`timescale 1ns/100ps
`default_nettype none
module wlv_link_properties (
  // link clock domain
  input wire logic ck,
  input wire logic reset_link,
  // link wires
  input wire wlv_pkg::wlv_cmd_t cmd,
  input wire logic mode_register_one_sel,
  input wire logic [wlv_pkg::ADDR_W-1:0] addr,
  input wire logic termination_enable_input,
  input wire logic strobe_oe_n,
  input wire logic upper_lane_strobe,
  input wire logic lower_lane_strobe,
  input wire logic dq_oe_n,
  input wire logic [wlv_pkg::DQ_W-1:0] dq
);
  logic lvl_q, lvl_d, stb_q, mr1, mrs, rise;
  logic [12:0] mrs_q, mrs_d, trm_q, trm_d, drv_q, drv_d, cap_q, cap_d;
  assign mrs = cmd == wlv_pkg::WLV_CMD_MRS;
  assign mr1 = mrs && mode_register_one_sel;
  assign rise = lower_lane_strobe & ~stb_q;
  // cycle counters since mode write, termination on, strobes driven, first edge
  always_comb begin
    lvl_d = mr1 ? addr[wlv_pkg::LEVEL_BIT] : lvl_q;
    mrs_d = mrs ? 13'h0001 : mrs_q + {12'h000, ~&mrs_q};
    trm_d = termination_enable_input ? trm_q + {12'h000, ~&trm_q} : 13'h0000;
    drv_d = strobe_oe_n ? 13'h0000 : drv_q + {12'h000, ~&drv_q};
    cap_d = !lvl_q ? 13'h0000 : (rise || cap_q != 0) ? cap_q + {12'h000, ~&cap_q} : cap_q;
  end
  always_ff @(posedge ck) begin
    if (reset_link) begin
      lvl_q <= 1'b0;
      stb_q <= 1'b0;
      mrs_q <= 13'h1FFF;
      trm_q <= 13'h0000;
      drv_q <= 13'h0000;
      cap_q <= 13'h0000;
    end else begin
      lvl_q <= lvl_d;
      stb_q <= lower_lane_strobe;
      mrs_q <= mrs_d;
      trm_q <= trm_d;
      drv_q <= drv_d;
      cap_q <= cap_d;
    end
  end
  default clocking @(posedge ck); endclocking
  default disable iff (reset_link);
  property p_cmd_legal;
    lvl_q |-> cmd != wlv_pkg::WLV_CMD_OTHER && (!mrs || mode_register_one_sel);
  endproperty
  a_cmd_legal: assert property (p_cmd_legal) else $error("bad command in leveling");
  property p_strobe_lvl;
    !strobe_oe_n |-> lvl_q && termination_enable_input;
  endproperty
  a_strobe_lvl: assert property (p_strobe_lvl) else $error("strobes driven out of mode");
  property p_term_wait;
    $rose(termination_enable_input) && lvl_q |-> mrs_q >= wlv_pkg::MODE_TO_CMD_NCK;
  endproperty
  a_term_wait: assert property (p_term_wait) else $error("termination too early");
  property p_strobe_wait;
    $fell(strobe_oe_n) |-> trm_q >= wlv_pkg::STROBE_EN_NCK;
  endproperty
  a_strobe_wait: assert property (p_strobe_wait) else $error("strobes driven too early");
  property p_first_edge;
    rise |-> drv_q >= wlv_pkg::FIRST_STROBE_NCK;
  endproperty
  a_first_edge: assert property (p_first_edge) else $error("strobe edge too early");
  property p_feedback;
    lvl_q && !dq_oe_n && cap_q > wlv_pkg::LVL_OUT_NCK + wlv_pkg::LVL_ERR_NCK + 1
      |-> dq[7:0] inside {8'h00, 8'hFF} && dq[15:8] inside {8'h00, 8'hFF};
  endproperty
  a_feedback: assert property (p_feedback) else $error("lane bits disagree");
  property p_lanes_match;
    lvl_q && !dq_oe_n && cap_q > wlv_pkg::LVL_OUT_NCK + wlv_pkg::LVL_ERR_NCK + 1
      |-> dq[15:8] == dq[7:0];
  endproperty
  a_lanes_match: assert property (p_lanes_match) else $error("lanes differ");
  property p_exit_order;
    mr1 && lvl_q && !addr[wlv_pkg::LEVEL_BIT]
      |-> strobe_oe_n && !termination_enable_input && !$past(termination_enable_input);
  endproperty
  a_exit_order: assert property (p_exit_order) else $error("exit out of order");
  property p_mrs_gap;
    mrs |-> mrs_q >= wlv_pkg::MODE_CYCLE_NCK;
  endproperty
  a_mrs_gap: assert property (p_mrs_gap) else $error("mode writes too close");
  c_enter: cover property (mr1 && addr[wlv_pkg::LEVEL_BIT]);
  c_edge: cover property (rise);
  c_one: cover property (lvl_q && !dq_oe_n && dq[0] && dq[8]);
  c_exit: cover property (mr1 && lvl_q && !addr[wlv_pkg::LEVEL_BIT]);
endmodule
`default_nettype wire

/* File: test/ddr3_write_leveling_test.sv */
/*
  ddr3_write_leveling_test: controller and device joined by the link.
  assumes: controller makes ck; software reaches the controller over apb.
*/
`timescale 1ns/100ps
`default_nettype none
module ddr3_write_leveling_test;
  localparam int DLY = 3;
  logic clk = 1'b0, reset = 1'b1, reset_link = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er, od;
  logic [11:0] paddr = 12'h000, a;
  logic [31:0] pwdata = 32'h0, prdata, rd, lfsr = 32'hBE05;
  logic lvl, odis, sterm, dterm, cready, mready, illegal;
  int n_mismatch = 0, checks_done = 0, cycles = 0, n_illegal = 0;
  always #4 clk = ~clk;
  wlv_link_if u_wlv_link_if ();
  wlv_controller #(.DLY_W(DLY)) u_wlv_controller (.clk(clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(u_wlv_link_if.ctl));
  wlv_device u_wlv_device (.link(u_wlv_link_if.dev), .reset(reset_link),
    .leveling_active(lvl), .output_disabled(odis), .strobe_term_on(sterm),
    .dq_term_on(dterm), .cmd_ready(cready), .mrs_ready(mready), .illegal_cmd(illegal));
  wlv_link_properties u_wlv_link_properties (.ck(u_wlv_link_if.ck),
    .reset_link(reset_link), .cmd(u_wlv_link_if.cmd),
    .mode_register_one_sel(u_wlv_link_if.mode_register_one_sel),
    .addr(u_wlv_link_if.addr),
    .termination_enable_input(u_wlv_link_if.termination_enable_input),
    .strobe_oe_n(u_wlv_link_if.strobe_oe_n),
    .upper_lane_strobe(u_wlv_link_if.upper_lane_strobe),
    .lower_lane_strobe(u_wlv_link_if.lower_lane_strobe),
    .dq_oe_n(u_wlv_link_if.dq_oe_n), .dq(u_wlv_link_if.dq));
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
  endfunction
  // first delay whose strobe rise lands in the high half of ck
  function automatic logic [31:0] exp_result(input logic o);
    int d;
    d = 0;
    // outputs disabled: no feedback, both lanes run to the last delay unlocked
    if (o)
      return {16'h0, 5'h0, 3'h7, 5'h0, 3'h7};
    for (int k = 1; k < 2 ** DLY; k++) begin
      if (d == 0 && (k / wlv_pkg::CK_HALF) % 2 == 1 && ((k - 1) / wlv_pkg::CK_HALF) % 2 == 0)
        d = k;
    end
    return {14'h0, 2'b11, 5'h0, d[2:0], 5'h0, d[2:0]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0, rd, er);
    check(rd, exp);
  endtask
  always @(posedge u_wlv_link_if.ck) begin
    if (!reset_link && illegal !== 1'b0)
      n_illegal++;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge u_wlv_link_if.ck);
    reset_link <= 1'b0;
    @(posedge clk);
    rdchk(wlv_pkg::ADDR_CTRL, 32'h0);
    rdchk(wlv_pkg::ADDR_STATUS, 32'h0);
    check(32'({lvl, odis, sterm, dterm, cready, mready}), 32'h3);
    for (int i = 0; i < 3; i++) begin
      lfsr = lfsr_next(lfsr);
      a = {lfsr[11:2] | 10'h004, 2'b00};
      apb(1'b1, a, lfsr, rd, er);
      check(32'(er), 32'h1);
      apb(1'b0, a, 32'h0, rd, er);
      check({rd[30:0], er}, 32'h1);
    end
    rdchk(wlv_pkg::ADDR_STATUS, 32'h0);
    for (int r = 0; r < 3; r++) begin
      lfsr = lfsr_next(lfsr);
      od = (r < 2) ? r[0] : lfsr[0];
      apb(1'b1, wlv_pkg::ADDR_CTRL, {30'h0, od, 1'b1}, rd, er);
      apb(1'b1, wlv_pkg::ADDR_CTRL, {30'h0, ~od, 1'b1}, rd, er);
      apb(1'b0, wlv_pkg::ADDR_STATUS, 32'h0, rd, er);
      check(rd & 32'h7, 32'h1);
      while (lvl !== 1'b1) @(posedge clk);
      check(32'(odis), 32'(od));
      while (u_wlv_link_if.strobe_oe_n !== 1'b0) @(posedge clk);
      @(posedge clk);
      check(32'({sterm, dterm}), 32'h2);
      do apb(1'b0, wlv_pkg::ADDR_STATUS, 32'h0, rd, er); while (rd[1] !== 1'b1);
      check(rd, od ? 32'h6 : 32'h2);
      rdchk(wlv_pkg::ADDR_RESULT, exp_result(od));
      check(32'({lvl, dterm, cready}), 32'h1);
    end
    check(32'(n_illegal), 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
